// ### verilog/sroi_pkg.sv
package sroi_pkg;
  localparam int unsigned SENSOR_W = 2048;
  localparam int unsigned SENSOR_H = 2048;
  localparam int unsigned CW = 12;
  localparam int unsigned DW = 12;
  localparam int unsigned NBAND = 8;
  localparam int unsigned BIW = 3;
  localparam int unsigned SUMW = 36;
  localparam int unsigned CNTW = 24;
  // Every line takes the full sensor width in cycles, whatever the window width
  localparam logic [CW-1:0] LINE_LAST = 12'h7ff;
  localparam logic [CW:0] SENSOR_W_13 = 13'h0800;
  localparam logic [CW:0] SENSOR_H_13 = 13'h0800;
  localparam logic [CW-1:0] RST_WIN_W = 12'h800;
  localparam logic [CW-1:0] RST_WIN_H = 12'h800;
  localparam logic [CW-1:0] RST_OFS = 12'h000;
  localparam logic [CW-1:0] RST_BAND_W = 12'h800;
  localparam logic [CW-1:0] RST_BAND_H = 12'h002;
  localparam logic [CW-1:0] MIN_WIN_W = 12'h100;
  localparam logic [CW-1:0] MIN_WIN_H = 12'h004;
  localparam logic [CW-1:0] MIN_BAND_H = 12'h002;
  localparam logic [CW-1:0] MAX_DIM = 12'h800;

  typedef enum logic [4:0] {
    SROI_WIN_W = 5'h00,
    SROI_WIN_H = 5'h01,
    SROI_WIN_OX = 5'h02,
    SROI_WIN_OY = 5'h03,
    SROI_STACK_MODE = 5'h04,
    SROI_BAND_SEL = 5'h05,
    SROI_BAND_EN = 5'h06,
    SROI_BAND_W = 5'h07,
    SROI_BAND_H = 5'h08,
    SROI_BAND_OX = 5'h09,
    SROI_BAND_OY = 5'h0a,
    SROI_WB_COL = 5'h0b,
    SROI_WB_ROW = 5'h0c,
    SROI_WB_W = 5'h0d,
    SROI_WB_H = 5'h0e,
    SROI_START = 5'h0f
  } sroi_cmd_e;

  typedef enum logic [1:0] {
    SROI_IDLE = 2'b00,
    SROI_LINE = 2'b01,
    SROI_TAIL = 2'b11
  } sroi_state_e;
endpackage

// ### verilog/sroi_link_if.sv
interface sroi_link_if;
  import sroi_pkg::*;
  logic cmd_valid;
  sroi_cmd_e cmd_code;
  logic [CW-1:0] cmd_data;
  logic cmd_ready;
  logic fval;
  logic lval;
  logic dval;
  logic [DW-1:0] pdata;
  modport dev (
    input cmd_valid, cmd_code, cmd_data,
    output cmd_ready, fval, lval, dval, pdata
  );
  modport host (
    output cmd_valid, cmd_code, cmd_data,
    input cmd_ready, fval, lval, dval, pdata
  );
endinterface

// ### verilog/sroi_awb_stat.sv
module sroi_awb_stat
  import sroi_pkg::*;
#(
  parameter int unsigned PW = DW
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic pix_ok,
  input wire logic [CW-1:0] col,
  input wire logic [CW-1:0] row,
  input wire logic [PW-1:0] data,
  input wire logic wb_set,
  input wire logic [CW-1:0] wb_col,
  input wire logic [CW-1:0] wb_row,
  input wire logic [CW-1:0] wb_w,
  input wire logic [CW-1:0] wb_h,
  output logic [SUMW-1:0] sum_ff,
  output logic [CNTW-1:0] cnt_ff
);
  logic in_win;
  logic [SUMW-1:0] nxt_sum;
  logic [CNTW-1:0] nxt_cnt;

  always_comb begin
    // Only streamed pixels arrive here, so this is the overlap with the image window
    in_win = !wb_set || (({1'b0, col} >= {1'b0, wb_col}) &&
             ({1'b0, col} < ({1'b0, wb_col} + {1'b0, wb_w})) &&
             ({1'b0, row} >= {1'b0, wb_row}) &&
             ({1'b0, row} < ({1'b0, wb_row} + {1'b0, wb_h})));
    nxt_sum = sum_ff;
    nxt_cnt = cnt_ff;
    if (clr) begin
      nxt_sum = '0;
      nxt_cnt = '0;
    end else if (pix_ok && in_win) begin
      nxt_sum = sum_ff + SUMW'(data);
      nxt_cnt = cnt_ff + CNTW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_ff <= '0;
      cnt_ff <= '0;
    end else begin
      sum_ff <= nxt_sum;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // sroi_awb_stat

// ### verilog/sroi_dev.sv
// Function
// - Stream only pixels inside the window
// - Coordinates start at top-left pixel zero
// - Fewer rows shorten frame; width keeps line
// - Host keeps width plus x offset legal
// - Host keeps height plus y offset legal
// - Window size resets to maximum
// - Host programs width in steps of 16
// - Host programs height in steps of 4
// - Host keeps width>=256 and height>=4
// - Eight bands, indexed zero to seven
// - Stacked mode reads only band pixels
// - Enabled bands joined into one frame
// - All bands share width and x offset
// - Selector picks band for later writes
// - Band enable includes or drops band
// - Frame width shared; height sums bands
// - Host keeps band x plus width legal
// - Host checks band y plus height against its own copy, which select resets to y 0 and height 2
// - Host band x, width multiples of 16
// - Host band y, height even values
// - Balance window: column, row, width, height
// - Balance statistics use window overlap only
// - Unset balance window uses image window
module sroi_dev
  import sroi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  sroi_link_if.dev lnk,
  output logic sen_rd,
  output logic [CW-1:0] sen_col,
  output logic [CW-1:0] sen_row,
  input wire logic [DW-1:0] sen_data,
  output logic [SUMW-1:0] awb_sum,
  output logic [CNTW-1:0] awb_cnt,
  output logic cfg_err
);
  logic [CW-1:0] win_w_ff, win_h_ff, win_ox_ff, win_oy_ff;
  logic [CW-1:0] nxt_win_w, nxt_win_h, nxt_win_ox, nxt_win_oy;
  logic stk_ff, nxt_stk, wb_set_ff, nxt_wb_set, take, found;
  logic [BIW-1:0] sel_ff, nxt_sel;
  logic [NBAND-1:0] ben_ff, nxt_ben;
  logic [CW-1:0] bh_ff [NBAND], nxt_bh [NBAND];
  logic [CW-1:0] boy_ff [NBAND], nxt_boy [NBAND];
  logic [CW-1:0] bw_ff, box_ff, nxt_bw, nxt_box;
  logic [CW-1:0] wbc_ff, wbr_ff, wbw_ff, wbh_ff;
  logic [CW-1:0] nxt_wbc, nxt_wbr, nxt_wbw, nxt_wbh;
  sroi_state_e st_ff, nxt_st;
  logic [CW-1:0] row_ff, col_ff, left_ff, nxt_row, nxt_col, nxt_left;
  logic [NBAND-1:0] done_ff, nxt_done;
  logic rdy_ff, fval_ff, lval_ff, dval_ff, rd_ff, err_ff;
  logic nxt_rdy, nxt_fval, nxt_lval, nxt_dval, nxt_rd, nxt_err;
  logic [CW-1:0] scol_ff, srow_ff, nxt_scol, nxt_srow, eff_w, eff_ox;
  logic [DW-1:0] pd_ff, nxt_pd;
  logic [BIW-1:0] pick;
  assign take = lnk.cmd_valid && rdy_ff;

  // Parameter store, written only while idle so a frame sees stable settings
  always_comb begin
    nxt_win_w = win_w_ff;
    nxt_win_h = win_h_ff;
    nxt_win_ox = win_ox_ff;
    nxt_win_oy = win_oy_ff;
    nxt_stk = stk_ff;
    nxt_sel = sel_ff;
    nxt_ben = ben_ff;
    nxt_bh = bh_ff;
    nxt_boy = boy_ff;
    nxt_bw = bw_ff;
    nxt_box = box_ff;
    nxt_wbc = wbc_ff;
    nxt_wbr = wbr_ff;
    nxt_wbw = wbw_ff;
    nxt_wbh = wbh_ff;
    nxt_wb_set = wb_set_ff;
    if (take) begin
      case (lnk.cmd_code)
        SROI_WIN_W: nxt_win_w = lnk.cmd_data;
        SROI_WIN_H: nxt_win_h = lnk.cmd_data;
        SROI_WIN_OX: nxt_win_ox = lnk.cmd_data;
        SROI_WIN_OY: nxt_win_oy = lnk.cmd_data;
        SROI_STACK_MODE: nxt_stk = lnk.cmd_data[0];
        SROI_BAND_SEL: nxt_sel = lnk.cmd_data[BIW-1:0];
        SROI_BAND_EN: nxt_ben[sel_ff] = lnk.cmd_data[0];
        SROI_BAND_W: nxt_bw = lnk.cmd_data;
        SROI_BAND_H: nxt_bh[sel_ff] = lnk.cmd_data;
        SROI_BAND_OX: nxt_box = lnk.cmd_data;
        SROI_BAND_OY: nxt_boy[sel_ff] = lnk.cmd_data;
        SROI_WB_COL: nxt_wbc = lnk.cmd_data;
        SROI_WB_ROW: nxt_wbr = lnk.cmd_data;
        SROI_WB_W: nxt_wbw = lnk.cmd_data;
        SROI_WB_H: nxt_wbh = lnk.cmd_data;
        default: ;
      endcase
      if (lnk.cmd_code inside {SROI_WB_COL, SROI_WB_ROW, SROI_WB_W, SROI_WB_H}) begin
        nxt_wb_set = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_w_ff <= RST_WIN_W;
      win_h_ff <= RST_WIN_H;
      win_ox_ff <= RST_OFS;
      win_oy_ff <= RST_OFS;
      stk_ff <= 1'b0;
      sel_ff <= '0;
      ben_ff <= '0;
      for (int i = 0; i < NBAND; i++) begin
        bh_ff[i] <= RST_BAND_H;
        boy_ff[i] <= RST_OFS;
      end
      bw_ff <= RST_BAND_W;
      box_ff <= RST_OFS;
      wbc_ff <= RST_OFS;
      wbr_ff <= RST_OFS;
      wbw_ff <= RST_WIN_W;
      wbh_ff <= RST_WIN_H;
      wb_set_ff <= 1'b0;
    end else begin
      win_w_ff <= nxt_win_w;
      win_h_ff <= nxt_win_h;
      win_ox_ff <= nxt_win_ox;
      win_oy_ff <= nxt_win_oy;
      stk_ff <= nxt_stk;
      sel_ff <= nxt_sel;
      ben_ff <= nxt_ben;
      bh_ff <= nxt_bh;
      boy_ff <= nxt_boy;
      bw_ff <= nxt_bw;
      box_ff <= nxt_box;
      wbc_ff <= nxt_wbc;
      wbr_ff <= nxt_wbr;
      wbw_ff <= nxt_wbw;
      wbh_ff <= nxt_wbh;
      wb_set_ff <= nxt_wb_set;
    end
  end

  // Next band: enabled, not yet sent, lowest top row
  always_comb begin
    found = 1'b0;
    pick = '0;
    for (int i = 0; i < NBAND; i++) begin
      if (ben_ff[i] && !done_ff[i] && (!found || boy_ff[i] < boy_ff[pick])) begin
        found = 1'b1;
        pick = BIW'(i);
      end
    end
  end
  assign eff_w = stk_ff ? bw_ff : win_w_ff;
  assign eff_ox = stk_ff ? box_ff : win_ox_ff;
  // Readout sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_row = row_ff;
    nxt_col = col_ff;
    nxt_left = left_ff;
    nxt_done = done_ff;
    nxt_err = err_ff;
    case (st_ff)
      SROI_IDLE: begin
        if (take && lnk.cmd_code == SROI_START) begin
          nxt_col = '0;
          nxt_row = stk_ff ? boy_ff[pick] : win_oy_ff;
          nxt_left = stk_ff ? bh_ff[pick] : win_h_ff;
          nxt_done[pick] = stk_ff && found;
          nxt_err = stk_ff && !found;
          if (!stk_ff || found) begin
            nxt_st = SROI_LINE;
          end
        end
      end
      SROI_LINE: begin
        nxt_col = col_ff + CW'(1);
        // Line length is fixed, so only the row count sets the frame time
        if (col_ff == LINE_LAST) begin
          nxt_col = '0;
          nxt_row = row_ff + CW'(1);
          nxt_left = left_ff - CW'(1);
          if (left_ff == CW'(1)) begin
            if (stk_ff && found) begin
              nxt_row = boy_ff[pick];
              nxt_left = bh_ff[pick];
              nxt_done[pick] = 1'b1;
            end else begin
              nxt_st = SROI_TAIL;
            end
          end
        end
      end
      SROI_TAIL: begin
        nxt_st = SROI_IDLE;
        nxt_done = '0;
      end
      default: nxt_st = SROI_IDLE;
    endcase
    nxt_rd = (nxt_st == SROI_LINE) && (nxt_col < eff_w);
    nxt_scol = eff_ox + nxt_col;
    nxt_srow = nxt_row;
    nxt_rdy = (nxt_st == SROI_IDLE);
    nxt_fval = (st_ff != SROI_IDLE);
    nxt_lval = rd_ff;
    nxt_dval = rd_ff;
    nxt_pd = rd_ff ? sen_data : pd_ff;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= SROI_IDLE;
      row_ff <= '0;
      col_ff <= '0;
      left_ff <= '0;
      done_ff <= '0;
      err_ff <= 1'b0;
      rd_ff <= 1'b0;
      scol_ff <= '0;
      srow_ff <= '0;
      rdy_ff <= 1'b0;
      fval_ff <= 1'b0;
      lval_ff <= 1'b0;
      dval_ff <= 1'b0;
      pd_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      row_ff <= nxt_row;
      col_ff <= nxt_col;
      left_ff <= nxt_left;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      rd_ff <= nxt_rd;
      scol_ff <= nxt_scol;
      srow_ff <= nxt_srow;
      rdy_ff <= nxt_rdy;
      fval_ff <= nxt_fval;
      lval_ff <= nxt_lval;
      dval_ff <= nxt_dval;
      pd_ff <= nxt_pd;
    end
  end

  sroi_awb_stat #(.PW(DW)) u_awb (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clr(take && lnk.cmd_code == SROI_START),
    .pix_ok(rd_ff),
    .col(scol_ff),
    .row(srow_ff),
    .data(sen_data),
    .wb_set(wb_set_ff),
    .wb_col(wbc_ff),
    .wb_row(wbr_ff),
    .wb_w(wbw_ff),
    .wb_h(wbh_ff),
    .sum_ff(awb_sum),
    .cnt_ff(awb_cnt)
  );

  assign sen_rd = rd_ff;
  assign sen_col = scol_ff;
  assign sen_row = srow_ff;
  assign cfg_err = err_ff;
  assign lnk.cmd_ready = rdy_ff;
  assign lnk.fval = fval_ff;
  assign lnk.lval = lval_ff;
  assign lnk.dval = dval_ff;
  assign lnk.pdata = pd_ff;
endmodule // sroi_dev

// ### verilog/sroi_host.sv
module sroi_host
  import sroi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  sroi_link_if.host lnk,
  input wire logic usr_cmd_valid,
  input wire sroi_cmd_e usr_cmd_code,
  input wire logic [CW-1:0] usr_cmd_data,
  output logic usr_cmd_ready,
  output logic cmd_rej,
  output logic cap_valid,
  output logic [DW-1:0] cap_data,
  output logic frame_done,
  output logic [CW:0] cap_width,
  output logic [CW:0] cap_height
);
  logic hv_ff, nxt_hv, urdy_ff, nxt_urdy, rej_ff, nxt_rej;
  sroi_cmd_e hc_ff, nxt_hc;
  logic [CW-1:0] hd_ff, nxt_hd;
  logic [CW:0] sw_ff, sh_ff, sox_ff, soy_ff, sbw_ff, sbox_ff, sboy_ff, sbh_ff;
  logic [CW:0] nxt_sw, nxt_sh, nxt_sox, nxt_soy, nxt_sbw, nxt_sbox, nxt_sboy, nxt_sbh;
  logic [CW:0] d;
  logic accept, ok;

  assign accept = usr_cmd_valid && urdy_ff;
  assign d = {1'b0, usr_cmd_data};

  // Commands that would break the device's window limits are not forwarded
  always_comb begin
    nxt_sw = sw_ff;
    nxt_sh = sh_ff;
    nxt_sox = sox_ff;
    nxt_soy = soy_ff;
    nxt_sbw = sbw_ff;
    nxt_sbox = sbox_ff;
    nxt_sboy = sboy_ff;
    nxt_sbh = sbh_ff;
    ok = 1'b1;
    case (usr_cmd_code)
      SROI_WIN_W: begin
        ok = (d[3:0] == 4'h0) && (d >= {1'b0, MIN_WIN_W}) && (d + sox_ff <= SENSOR_W_13);
        nxt_sw = d;
      end
      SROI_WIN_H: begin
        ok = (d[1:0] == 2'h0) && (d >= {1'b0, MIN_WIN_H}) && (d + soy_ff <= SENSOR_H_13);
        nxt_sh = d;
      end
      SROI_WIN_OX: begin
        ok = (d + sw_ff <= SENSOR_W_13);
        nxt_sox = d;
      end
      SROI_WIN_OY: begin
        ok = (d + sh_ff <= SENSOR_H_13);
        nxt_soy = d;
      end
      SROI_BAND_W: begin
        ok = (d[3:0] == 4'h0) && (d >= {1'b0, MIN_WIN_W}) && (d + sbox_ff <= SENSOR_W_13);
        nxt_sbw = d;
      end
      SROI_BAND_OX: begin
        ok = (d[3:0] == 4'h0) && (d + sbw_ff <= SENSOR_W_13);
        nxt_sbox = d;
      end
      SROI_BAND_SEL: begin
        nxt_sboy = '0;
        nxt_sbh = {1'b0, MIN_BAND_H};
      end
      SROI_BAND_H: begin
        ok = !d[0] && (d >= {1'b0, MIN_BAND_H}) && (d + sboy_ff <= SENSOR_H_13);
        nxt_sbh = d;
      end
      SROI_BAND_OY: begin
        ok = !d[0] && (d + sbh_ff <= SENSOR_H_13);
        nxt_sboy = d;
      end
      default: ok = 1'b1;
    endcase
    if (!(accept && ok)) begin
      nxt_sw = sw_ff;
      nxt_sh = sh_ff;
      nxt_sox = sox_ff;
      nxt_soy = soy_ff;
      nxt_sbw = sbw_ff;
      nxt_sbox = sbox_ff;
      nxt_sboy = sboy_ff;
      nxt_sbh = sbh_ff;
    end
    nxt_hv = (hv_ff && !lnk.cmd_ready) || (accept && ok);
    nxt_hc = (accept && ok) ? usr_cmd_code : hc_ff;
    nxt_hd = (accept && ok) ? usr_cmd_data : hd_ff;
    nxt_urdy = !nxt_hv;
    nxt_rej = accept && !ok;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hv_ff <= 1'b0;
      hc_ff <= SROI_WIN_W;
      hd_ff <= '0;
      urdy_ff <= 1'b0;
      rej_ff <= 1'b0;
      sw_ff <= {1'b0, RST_WIN_W};
      sh_ff <= {1'b0, RST_WIN_H};
      sox_ff <= '0;
      soy_ff <= '0;
      sbw_ff <= {1'b0, RST_BAND_W};
      sbox_ff <= '0;
      sboy_ff <= '0;
      sbh_ff <= {1'b0, MIN_BAND_H};
    end else begin
      hv_ff <= nxt_hv;
      hc_ff <= nxt_hc;
      hd_ff <= nxt_hd;
      urdy_ff <= nxt_urdy;
      rej_ff <= nxt_rej;
      sw_ff <= nxt_sw;
      sh_ff <= nxt_sh;
      sox_ff <= nxt_sox;
      soy_ff <= nxt_soy;
      sbw_ff <= nxt_sbw;
      sbox_ff <= nxt_sbox;
      sboy_ff <= nxt_sboy;
      sbh_ff <= nxt_sbh;
    end
  end

  // Frame capture: width of last line and count of lines
  logic cv_ff, fv_d_ff, lv_d_ff, fd_ff, nxt_fd;
  logic [DW-1:0] cd_ff;
  logic [CW:0] wc_ff, hc2_ff, nxt_wc, nxt_hc2, cw_ff, ch_ff, nxt_cw, nxt_ch;

  always_comb begin
    nxt_wc = wc_ff;
    nxt_hc2 = hc2_ff;
    nxt_cw = cw_ff;
    nxt_ch = ch_ff;
    if (lnk.dval) begin
      nxt_wc = wc_ff + (CW+1)'(1);
    end
    if (lv_d_ff && !lnk.lval) begin
      nxt_wc = '0;
      nxt_cw = wc_ff;
      nxt_hc2 = hc2_ff + (CW+1)'(1);
    end
    nxt_fd = fv_d_ff && !lnk.fval;
    if (nxt_fd) begin
      nxt_ch = hc2_ff;
      nxt_hc2 = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cv_ff <= 1'b0;
      cd_ff <= '0;
      fv_d_ff <= 1'b0;
      lv_d_ff <= 1'b0;
      fd_ff <= 1'b0;
      wc_ff <= '0;
      hc2_ff <= '0;
      cw_ff <= '0;
      ch_ff <= '0;
    end else begin
      cv_ff <= lnk.dval;
      cd_ff <= lnk.pdata;
      fv_d_ff <= lnk.fval;
      lv_d_ff <= lnk.lval;
      fd_ff <= nxt_fd;
      wc_ff <= nxt_wc;
      hc2_ff <= nxt_hc2;
      cw_ff <= nxt_cw;
      ch_ff <= nxt_ch;
    end
  end

  assign lnk.cmd_valid = hv_ff;
  assign lnk.cmd_code = hc_ff;
  assign lnk.cmd_data = hd_ff;
  assign usr_cmd_ready = urdy_ff;
  assign cmd_rej = rej_ff;
  assign cap_valid = cv_ff;
  assign cap_data = cd_ff;
  assign frame_done = fd_ff;
  assign cap_width = cw_ff;
  assign cap_height = ch_ff;
endmodule // sroi_host

// ### bench/sroi_link_chk.sv
module sroi_link_chk
  import sroi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire sroi_cmd_e cmd_code,
  input wire logic [CW-1:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic fval,
  input wire logic lval,
  input wire logic dval,
  input wire logic [DW-1:0] pdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lq_ff, nxt_lq, seen_ff, nxt_seen, take_start;
  logic [12:0] gap_ff, nxt_gap, run_ff, nxt_run;
  assign take_start = cmd_valid && cmd_ready && (cmd_code == SROI_START);
  // Line period and run length of each line
  always_comb begin
    nxt_lq = lval;
    nxt_run = lval ? run_ff + 13'h0001 : 13'h0000;
    nxt_gap = (lval && !lq_ff) ? 13'h0001 : gap_ff + 13'h0001;
    nxt_seen = fval && (seen_ff || (lval && !lq_ff));
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lq_ff <= 1'b0;
      seen_ff <= 1'b0;
      gap_ff <= 13'h0000;
      run_ff <= 13'h0000;
    end else begin
      lq_ff <= nxt_lq;
      seen_ff <= nxt_seen;
      gap_ff <= nxt_gap;
      run_ff <= nxt_run;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence frame_lead_s;
    lval [*8];
  endsequence
  sequence line_end_s;
    $fell(lval);
  endsequence
  dval_match_a: assert property (dval == lval && (dval || $stable(pdata)))
    else $error("dval differs from lval");
  lval_frame_a: assert property (lval |-> fval)
    else $error("pixel outside frame");
  ready_busy_a: assert property ($rose(fval) |-> !cmd_ready ##1 !cmd_ready)
    else $error("command ready during frame");
  frame_start_a: assert property ($rose(fval) |-> $past(take_start, 2))
    else $error("frame without start");
  frame_lead_a: assert property ($rose(fval) |-> frame_lead_s)
    else $error("frame does not open with pixels");
  line_width_a: assert property (line_end_s |-> run_ff >= 13'h0100 && run_ff[3:0] == 4'h0)
    else $error("line pixel count wrong");
  line_period_a: assert property ($rose(lval) && seen_ff |-> gap_ff == 13'h0800)
    else $error("line period not full sensor width");
  ready_back_a: assert property ($fell(fval) |-> ##[0:3] cmd_ready)
    else $error("ready not back after frame");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code)
    && $stable(cmd_data))
    else $error("command dropped before taken");
endmodule // sroi_link_chk

// ### bench/tb_sensor_roi_windowing.sv
module tb_sensor_roi_windowing;
  import sroi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b, usr_cmd_valid, usr_cmd_ready, cmd_rej, cap_valid, frame_done, cfg_err, sen_rd;
  sroi_cmd_e usr_cmd_code;
  logic [CW-1:0] usr_cmd_data, sen_col, sen_row;
  logic [DW-1:0] sen_data, cap_data;
  logic [CW:0] cap_width, cap_height;
  logic [SUMW-1:0] awb_sum, es;
  logic [CNTW-1:0] awb_cnt, ec;
  logic [DW-1:0] exp_q[$];
  int err_count = 0, num_checks = 0, cyc = 0, flen = 0, f4, ox, oy, bx, ya, yb, rnd;
  int wbc = 0, wbr = 0, wbw = 2048, wbh = 2048;
  always #2.5 core_clk = ~core_clk;
  sroi_link_if lnk();
  sroi_dev sroi_dev_i (.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk), .sen_rd(sen_rd),
    .sen_col(sen_col), .sen_row(sen_row), .sen_data(sen_data), .awb_sum(awb_sum),
    .awb_cnt(awb_cnt), .cfg_err(cfg_err));
  sroi_host sroi_host_i (.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk),
    .usr_cmd_valid(usr_cmd_valid), .usr_cmd_code(usr_cmd_code), .usr_cmd_data(usr_cmd_data),
    .usr_cmd_ready(usr_cmd_ready), .cmd_rej(cmd_rej), .cap_valid(cap_valid),
    .cap_data(cap_data), .frame_done(frame_done), .cap_width(cap_width),
    .cap_height(cap_height));
  sroi_link_chk sroi_link_chk_i (.core_clk(core_clk), .rst_b(rst_b),
    .cmd_valid(lnk.cmd_valid), .cmd_code(lnk.cmd_code), .cmd_data(lnk.cmd_data),
    .cmd_ready(lnk.cmd_ready), .fval(lnk.fval), .lval(lnk.lval), .dval(lnk.dval),
    .pdata(lnk.pdata));
  // Sensor array: pixel value depends on its column and row
  // Unaddressed reads return all ones, so a stray read shows up as a bad pixel
  assign sen_data = sen_rd ? (sen_col ^ {sen_row[5:0], 6'h00}) : 12'hfff;
  function automatic logic [DW-1:0] pix(input int c, input int r);
    pix = 12'(c) ^ 12'((r % 64) * 64);
  endfunction
  task automatic chk(input logic [SUMW-1:0] got, input logic [SUMW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic send(input sroi_cmd_e c, input int d, input logic rej);
    int n;
    n = 0;
    usr_cmd_code = c;
    usr_cmd_data = 12'(d);
    usr_cmd_valid = 1'b1;
    while (usr_cmd_ready !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    usr_cmd_valid = 1'b0;
    chk(cmd_rej, rej);
    @(posedge core_clk);
    #1;
  endtask
  // Expected pixels of a window, and its balance statistics
  task automatic fill(input int x, input int y, input int w, input int h);
    for (int r = y; r < y + h; r++) begin
      for (int c = x; c < x + w; c++) begin
        exp_q.push_back(pix(c, r));
        if (c >= wbc && c < wbc + wbw && r >= wbr && r < wbr + wbh) begin
          es += pix(c, r);
          ec++;
        end
      end
    end
  endtask
  task automatic frame(input int h, input int w);
    int n;
    n = 0;
    flen = 0;
    send(SROI_START, 0, 1'b0);
    while (frame_done !== 1'b1 && n < 40000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(cap_height, h);
    chk(cap_width, w);
    chk(exp_q.size(), 0);
    chk(awb_sum, es);
    chk(awb_cnt, ec);
    es = 0;
    ec = 0;
  endtask
  always @(posedge core_clk) begin
    if (lnk.fval === 1'b1) flen <= flen + 1;
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      err_count++;
      results();
    end
  end
  always @(negedge core_clk) begin
    if (cap_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(cap_valid, 1'b0);
      else chk(cap_data, exp_q.pop_front());
    end
  end
  initial begin
    rst_b = 1'b0;
    usr_cmd_valid = 1'b0;
    usr_cmd_code = SROI_WIN_W;
    usr_cmd_data = 12'h000;
    es = 0;
    ec = 0;
    rnd = $urandom(32'ha10cc39d);
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    // Illegal values right after reset; offsets fail as size is still maximum
    send(SROI_WIN_OX, 16, 1'b1);
    send(SROI_WIN_OY, 4, 1'b1);
    send(SROI_WIN_W, 264, 1'b1);
    send(SROI_WIN_W, 240, 1'b1);
    send(SROI_WIN_H, 6, 1'b1);
    send(SROI_BAND_H, 3, 1'b1);
    send(SROI_BAND_OX, 8, 1'b1);
    ox = 16 * ($urandom % 64);
    oy = 4 * ($urandom % 256);
    send(SROI_WIN_W, 256, 1'b0);
    send(SROI_WIN_H, 4, 1'b0);
    send(SROI_WIN_OX, ox, 1'b0);
    send(SROI_WIN_OY, oy, 1'b0);
    fill(ox, oy, 256, 4);
    frame(4, 256);
    f4 = flen;
    send(SROI_WIN_H, 8, 1'b0);
    fill(ox, oy, 256, 8);
    frame(8, 256);
    chk(flen - f4, 4 * 2048);
    wbc = ox + 128;
    wbr = oy + 2;
    wbw = 1024;
    wbh = 16;
    send(SROI_WB_COL, wbc, 1'b0);
    send(SROI_WB_ROW, wbr, 1'b0);
    send(SROI_WB_W, wbw, 1'b0);
    send(SROI_WB_H, wbh, 1'b0);
    send(SROI_WIN_W, 512, 1'b0);
    send(SROI_WIN_H, 4, 1'b0);
    fill(ox, oy, 512, 4);
    frame(4, 512);
    chk(flen, f4);
    // Two bands, the higher index lies higher on the sensor and comes first
    bx = 16 * ($urandom % 100);
    ya = 1000 + 2 * ($urandom % 100);
    yb = 2 * ($urandom % 200);
    send(SROI_STACK_MODE, 1, 1'b0);
    send(SROI_BAND_W, 256, 1'b0);
    send(SROI_BAND_OX, bx, 1'b0);
    send(SROI_BAND_SEL, 2, 1'b0);
    send(SROI_BAND_EN, 1, 1'b0);
    send(SROI_BAND_OY, ya, 1'b0);
    send(SROI_BAND_H, 2, 1'b0);
    send(SROI_BAND_SEL, 5, 1'b0);
    send(SROI_BAND_EN, 1, 1'b0);
    send(SROI_BAND_OY, yb, 1'b0);
    send(SROI_BAND_H, 4, 1'b0);
    fill(bx, yb, 256, 4);
    fill(bx, ya, 256, 2);
    frame(6, 256);
    send(SROI_BAND_EN, 0, 1'b0);
    send(SROI_BAND_SEL, 2, 1'b0);
    send(SROI_BAND_EN, 0, 1'b0);
    send(SROI_START, 0, 1'b0);
    chk(cfg_err, 1'b1);
    chk(lnk.fval, 1'b0);
    send(SROI_BAND_SEL, 7, 1'b0);
    send(SROI_BAND_EN, 1, 1'b0);
    send(SROI_BAND_OY, 2046, 1'b0);
    fill(bx, 2046, 256, 2);
    frame(2, 256);
    // Same band again: a band sent in the last frame must not be skipped
    fill(bx, 2046, 256, 2);
    frame(2, 256);
    chk(cfg_err, 1'b0);
    results();
  end
endmodule // tb_sensor_roi_windowing
